/* File: hdl/rpm_pkg.sv */
// Purpose: Shared constants and carriers for the root-port message queue registers
// Assumes: 32-bit Avalon-MM register access, byte addresses
// Notes: Offsets are byte addresses within the bridge register space
package rpm_pkg;
    localparam logic [11:0] RPM_OFS_STATUS_CONTROL = 12'h148;
    localparam logic [11:0] RPM_OFS_MSI_BASE_UPPER = 12'h14c;
    localparam logic [11:0] RPM_OFS_MSI_BASE_LOWER = 12'h150;
    localparam logic [11:0] RPM_OFS_ERROR_HEAD = 12'h154;
    localparam logic [11:0] RPM_OFS_INTR_HEAD = 12'h158;
    localparam logic [11:0] RPM_OFS_INTR_PAYLOAD = 12'h15c;
    localparam int RPM_BIT_FWD_ENABLE = 0;
    localparam int RPM_BIT_ERR_NOT_EMPTY = 16;
    localparam int RPM_BIT_ERR_OVERFLOW = 17;
    localparam int RPM_BIT_INT_NOT_EMPTY = 18;
    localparam int RPM_BIT_INT_OVERFLOW = 19;
    localparam int RPM_MSI_WINDOW_LSB = 12;
    localparam logic [31:0] RPM_RESET_WORD = 32'h0;
    localparam int RPM_DEFAULT_DEPTH = 16;

    typedef struct packed {
        logic [1:0] error_type;
        logic [15:0] source_a;
    } rpm_err_msg_s;

    typedef struct packed {
        logic is_msi;
        logic is_assert;
        logic [1:0] intx_line;
        logic [10:0] msi_addr;
        logic [15:0] source_a;
        logic [15:0] msi_data;
    } rpm_int_msg_s;

    typedef struct packed {
        logic [63:0] addr;
        logic [15:0] source_a;
        logic [15:0] data;
    } rpm_memwr_s;
endpackage

/* File: hdl/rpm_root_port_msg_fifo_regs.sv */
// Purpose: Root-port status/control, MSI window and error/interrupt message queues
// Assumes: One clock; messages arrive as single-cycle strobes from the link side
// Notes: Avalon-MM slave, waitrequest low one cycle after a request is seen
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rpm_root_port_msg_fifo_regs #(
    parameter int ERR_DEPTH = rpm_pkg::RPM_DEFAULT_DEPTH,
    parameter int INT_DEPTH = rpm_pkg::RPM_DEFAULT_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire logic i_is_root_port,
    input wire logic i_msi_64bit,
    input wire logic i_link_up,
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_err_msg_valid,
    input wire rpm_pkg::rpm_err_msg_s i_err_msg,
    input wire logic i_intx_msg_valid,
    input wire logic [15:0] i_intx_source_a,
    input wire logic [1:0] i_intx_line,
    input wire logic i_intx_assert,
    input wire logic i_memwr_valid,
    input wire rpm_pkg::rpm_memwr_s i_memwr,
    output logic o_memwr_is_msi,
    input wire logic i_axi_req,
    output logic o_axi_forward,
    output logic o_fwd_enable
);
    import rpm_pkg::*;

    localparam int EAW = (ERR_DEPTH > 1) ? $clog2(ERR_DEPTH) : 1;
    localparam int IAW = (INT_DEPTH > 1) ? $clog2(INT_DEPTH) : 1;

    // Storage arrays sized by parameter
    rpm_err_msg_s err_mem [ERR_DEPTH];
    rpm_int_msg_s int_mem [INT_DEPTH];
    logic [EAW-1:0] err_wp_q, err_rp_q;
    logic [IAW-1:0] int_wp_q, int_rp_q;
    logic [EAW:0] err_cnt_q;
    logic [IAW:0] int_cnt_q;
    logic err_ovf_q;
    logic int_ovf_q;
    logic fwd_en_q;
    logic link_up_q;
    logic [31:0] msi_upper_q;
    logic [19:0] msi_lower_q;

    function automatic logic [EAW-1:0] err_inc(input logic [EAW-1:0] p);
        err_inc = (p == EAW'(ERR_DEPTH - 1)) ? '0 : p + EAW'(1);
    endfunction

    function automatic logic [IAW-1:0] int_inc(input logic [IAW-1:0] p);
        int_inc = (p == IAW'(INT_DEPTH - 1)) ? '0 : p + IAW'(1);
    endfunction

    // Register select; every write decode goes through here
    function automatic logic reg_sel(input logic [11:0] a, input logic [11:0] ofs);
        reg_sel = (a == ofs);
    endfunction

    // Bus handshake: a request is seen in idle and accepted one cycle later
    typedef enum logic {
        BUS_IDLE,
        BUS_ACCEPT
    } rpm_bus_e;
    rpm_bus_e bus_q;

    // A request is accepted on the edge where waitrequest is low
    logic ack;
    logic req;
    logic wr_acc;
    logic rd_acc;
    assign ack = (bus_q == BUS_ACCEPT);
    assign req = (i_avs_read | i_avs_write) & ~ack;
    assign wr_acc = i_avs_write & ack;
    assign rd_acc = i_avs_read & ack;

    logic wr_sc;
    logic wr_up;
    logic wr_lo;
    logic pop_err;
    logic pop_int;
    assign wr_sc = wr_acc & reg_sel(i_avs_address, RPM_OFS_STATUS_CONTROL) & i_is_root_port;
    assign wr_up = wr_acc & reg_sel(i_avs_address, RPM_OFS_MSI_BASE_UPPER) & i_is_root_port;
    assign wr_lo = wr_acc & reg_sel(i_avs_address, RPM_OFS_MSI_BASE_LOWER) & i_is_root_port;
    assign pop_err = wr_acc & reg_sel(i_avs_address, RPM_OFS_ERROR_HEAD) & i_is_root_port
        & (err_cnt_q != '0);
    assign pop_int = wr_acc & i_is_root_port & (int_cnt_q != '0)
        & (reg_sel(i_avs_address, RPM_OFS_INTR_HEAD) | reg_sel(i_avs_address, RPM_OFS_INTR_PAYLOAD));

    // Single window compare; no vector table
    logic [31:0] win_upper;
    logic msi_hit;
    logic msi_push;
    logic intx_push;
    logic int_push;
    logic int_full;
    logic err_full;
    logic err_push;
    logic err_take;
    logic int_take;
    logic err_drop;
    // Upper window bits only take part with 64-bit addressing; 32-bit MSI writes carry zero there
    assign win_upper = i_msi_64bit ? msi_upper_q : '0;
    assign msi_hit = (i_memwr.addr[63:RPM_MSI_WINDOW_LSB] == {win_upper, msi_lower_q});
    assign msi_push = i_memwr_valid & msi_hit & i_is_root_port;
    assign intx_push = i_intx_msg_valid & i_is_root_port;
    assign int_push = msi_push | intx_push;
    assign int_full = (int_cnt_q == (IAW+1)'(INT_DEPTH));
    assign err_full = (err_cnt_q == (EAW+1)'(ERR_DEPTH));
    assign err_push = i_err_msg_valid & i_is_root_port;
    // A push into a full queue still lands when the head leaves in the same cycle
    assign err_take = err_push & (~err_full | pop_err);
    assign int_take = int_push & (~int_full | pop_int);
    assign err_drop = err_push & err_full & ~pop_err;

    // MSI wins when both kinds arrive together; the legacy one is counted as dropped
    rpm_int_msg_s int_new;
    always_comb begin
        int_new = '0;
        if (msi_push) begin
            int_new.is_msi = 1'b1;
            int_new.msi_addr = i_memwr.addr[12:2];
            int_new.source_a = i_memwr.source_a;
            int_new.msi_data = i_memwr.data;
        end else begin
            int_new.intx_line = i_intx_line;
            int_new.is_assert = i_intx_assert;
            int_new.source_a = i_intx_source_a;
        end
    end

    // Avalon handshake: one wait cycle, then ready
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus_q <= BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
        end else if (i_clk_en) begin
            case (bus_q)
                BUS_IDLE: begin
                    if (req) begin
                        bus_q <= BUS_ACCEPT;
                        o_avs_waitrequest <= 1'b0;
                    end
                end
                BUS_ACCEPT: begin
                    bus_q <= BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_q <= BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Storage has no reset: entries are only read once the count says they are valid
    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en & err_take) begin
            err_mem[err_wp_q] <= i_err_msg;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en & int_take) begin
            int_mem[int_wp_q] <= int_new;
        end
    end

    // Error queue
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            err_wp_q <= '0;
            err_rp_q <= '0;
            err_cnt_q <= '0;
        end else if (i_clk_en) begin
            if (err_take) begin
                err_wp_q <= err_inc(err_wp_q);
            end
            if (pop_err) begin
                err_rp_q <= err_inc(err_rp_q);
            end
            if (err_push & ~err_full & ~pop_err) begin
                err_cnt_q <= err_cnt_q + (EAW+1)'(1);
            end else if (pop_err & ~err_push) begin
                err_cnt_q <= err_cnt_q - (EAW+1)'(1);
            end
        end
    end

    // Interrupt queue
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            int_wp_q <= '0;
            int_rp_q <= '0;
            int_cnt_q <= '0;
        end else if (i_clk_en) begin
            if (int_take) begin
                int_wp_q <= int_inc(int_wp_q);
            end
            if (pop_int) begin
                int_rp_q <= int_inc(int_rp_q);
            end
            if (int_push & ~int_full & ~pop_int) begin
                int_cnt_q <= int_cnt_q + (IAW+1)'(1);
            end else if (pop_int & ~int_push) begin
                int_cnt_q <= int_cnt_q - (IAW+1)'(1);
            end
        end
    end

    // Sticky overflow flags; a new drop beats a clear in the same cycle
    logic int_drop;
    assign int_drop = (int_push & int_full & ~pop_int) | (msi_push & intx_push);
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            err_ovf_q <= 1'b0;
            int_ovf_q <= 1'b0;
        end else if (i_clk_en) begin
            if (err_drop) begin
                err_ovf_q <= 1'b1;
            end else if (wr_sc & i_avs_writedata[RPM_BIT_ERR_OVERFLOW] & i_avs_byteenable[2]) begin
                err_ovf_q <= 1'b0;
            end
            if (int_drop) begin
                int_ovf_q <= 1'b1;
            end else if (wr_sc & i_avs_writedata[RPM_BIT_INT_OVERFLOW] & i_avs_byteenable[2]) begin
                int_ovf_q <= 1'b0;
            end
        end
    end

    // Forwarding enable and link loss; link_up_q resets low so a release never looks like a fall
    logic link_fall;
    assign link_fall = link_up_q & ~i_link_up;
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fwd_en_q <= 1'b0;
            link_up_q <= 1'b0;
        end else if (i_clk_en) begin
            link_up_q <= i_link_up;
            if (link_fall) begin
                fwd_en_q <= 1'b0;
            end else if (wr_sc & i_avs_byteenable[0]) begin
                fwd_en_q <= i_avs_writedata[RPM_BIT_FWD_ENABLE];
            end
        end
    end

    // MSI base registers, byte-lane writes
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            msi_upper_q <= RPM_RESET_WORD;
            msi_lower_q <= '0;
        end else if (i_clk_en) begin
            for (int b = 0; b < 4; b++) begin
                if (wr_up & i_avs_byteenable[b]) begin
                    msi_upper_q[b*8 +: 8] <= i_avs_writedata[b*8 +: 8];
                end
            end
            if (wr_lo & i_avs_byteenable[1]) begin
                msi_lower_q[3:0] <= i_avs_writedata[15:12];
            end
            if (wr_lo & i_avs_byteenable[2]) begin
                msi_lower_q[11:4] <= i_avs_writedata[23:16];
            end
            if (wr_lo & i_avs_byteenable[3]) begin
                msi_lower_q[19:12] <= i_avs_writedata[31:24];
            end
        end
    end

    // Read mux; queue heads are combinational views of the array
    rpm_err_msg_s err_head;
    rpm_int_msg_s int_head;
    logic err_ne, int_ne;
    assign err_head = err_mem[err_rp_q];
    assign int_head = int_mem[int_rp_q];
    assign err_ne = (err_cnt_q != '0);
    assign int_ne = (int_cnt_q != '0);

    logic [31:0] rd_word;
    always_comb begin
        rd_word = '0;
        case (i_avs_address)
            RPM_OFS_STATUS_CONTROL: begin
                rd_word[RPM_BIT_FWD_ENABLE] = fwd_en_q;
                rd_word[RPM_BIT_ERR_NOT_EMPTY] = err_ne;
                rd_word[RPM_BIT_ERR_OVERFLOW] = err_ovf_q;
                rd_word[RPM_BIT_INT_NOT_EMPTY] = int_ne;
                rd_word[RPM_BIT_INT_OVERFLOW] = int_ovf_q;
            end
            RPM_OFS_MSI_BASE_UPPER: begin
                rd_word = i_msi_64bit ? msi_upper_q : '0;
            end
            RPM_OFS_MSI_BASE_LOWER: begin
                rd_word = {msi_lower_q, 12'h000};
            end
            RPM_OFS_ERROR_HEAD: begin
                if (err_ne) begin
                    rd_word[17:0] = err_head;
                    rd_word[18] = 1'b1;
                end
            end
            RPM_OFS_INTR_HEAD: begin
                if (int_ne) begin
                    rd_word = {1'b1, int_head.is_msi, int_head.is_assert, int_head.intx_line,
                        int_head.msi_addr, int_head.source_a};
                end
            end
            RPM_OFS_INTR_PAYLOAD: begin
                if (int_ne & int_head.is_msi) begin
                    rd_word[15:0] = int_head.msi_data;
                end
            end
            default: begin
                rd_word = '0;
            end
        endcase
        if (!i_is_root_port) begin
            rd_word = '0;
        end
    end

    // Readdata registered when the request is first seen so it stands at the accept edge
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_avs_readdata <= '0;
        end else if (i_clk_en) begin
            if (i_avs_read & req) begin
                o_avs_readdata <= rd_word;
            end else if (rd_acc) begin
                o_avs_readdata <= o_avs_readdata;
            end
        end
    end

    // Forwarding gate and MSI classification outputs
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_axi_forward <= 1'b0;
            o_memwr_is_msi <= 1'b0;
            o_fwd_enable <= 1'b0;
        end else if (i_clk_en) begin
            o_axi_forward <= i_axi_req & fwd_en_q;
            o_memwr_is_msi <= msi_push;
            o_fwd_enable <= fwd_en_q;
        end
    end
endmodule // rpm_root_port_msg_fifo_regs
`default_nettype wire

/* File: sim/rpm_checker.sv */
// Purpose: Port timing checks for the root-port message register block
// Assumes: i_clk_en held high by the bench
// Notes: Queue contents are judged by the bench
`timescale 1ns/10ps
`default_nettype none
module rpm_checker (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_is_root_port,
    input wire logic i_link_up,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_memwr_valid,
    input wire logic o_memwr_is_msi,
    input wire logic i_axi_req,
    input wire logic o_axi_forward,
    input wire logic o_fwd_enable
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic wr_acc = i_avs_write && !o_avs_waitrequest && i_is_root_port;
    AST_FWD_GATE: assert property (o_axi_forward == ($past(i_axi_req) && o_fwd_enable))
        else $error("forward output disagrees with request and enable");
    AST_EN_SOURCE: assert property ($rose(o_fwd_enable) |-> $past(wr_acc, 2))
        else $error("enable rose without an accepted write");
    AST_FWD_DROP: assert property ($fell(i_link_up) |-> ##[1:4] !o_fwd_enable)
        else $error("enable not cleared after link loss");
    AST_EN_FALL: assert property ($fell(o_fwd_enable) |->
        $past(wr_acc, 2) || !$past(i_link_up, 2) || !$past(i_link_up, 3) || !$past(i_link_up, 4))
        else $error("enable fell without write or link loss");
    AST_EP_READ: assert property (i_avs_read && !o_avs_waitrequest && !i_is_root_port
        && !$past(i_is_root_port) |-> o_avs_readdata == 32'h0)
        else $error("endpoint read returned nonzero");
    AST_MSI_CAUSE: assert property (o_memwr_is_msi |-> $past(i_memwr_valid) && $past(i_is_root_port))
        else $error("msi flag without a root-port memory write");
    AST_WAIT_ONE: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("request not answered after one wait cycle");
    AST_WAIT_HIGH: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
endmodule // rpm_checker
bind rpm_root_port_msg_fifo_regs rpm_checker rpm_checker_i (.i_sys_clk, .i_rst_b, .i_is_root_port,
    .i_link_up, .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_memwr_valid,
    .o_memwr_is_msi, .i_axi_req, .o_axi_forward, .o_fwd_enable);
`default_nettype wire

/* File: sim/rpm_link_model.sv */
// Purpose: Link-side source of error, legacy and memory-write messages
// Assumes: One-cycle valid pulses, as the block expects
// Notes: Fields flip after a pulse so a late sample cannot pass
`timescale 1ns/10ps
`default_nettype none
module rpm_link_model (
    input wire logic i_sys_clk,
    output logic o_err_valid,
    output rpm_pkg::rpm_err_msg_s o_err,
    output logic o_intx_valid,
    output logic [15:0] o_intx_src,
    output logic [1:0] o_intx_line,
    output logic o_intx_assert,
    output logic o_memwr_valid,
    output rpm_pkg::rpm_memwr_s o_memwr
);
    import rpm_pkg::*;
    initial begin
        {o_err_valid, o_err, o_intx_valid, o_intx_src, o_intx_line} = '0;
        {o_intx_assert, o_memwr_valid, o_memwr} = '0;
    end
    task automatic send_err(input rpm_err_msg_s m);
        @(posedge i_sys_clk);
        o_err_valid <= 1'b1;
        o_err <= m;
        @(posedge i_sys_clk);
        o_err_valid <= 1'b0;
        o_err <= ~m;
    endtask
    task automatic send_intx(input logic [15:0] s, input logic [1:0] ln, input logic a);
        @(posedge i_sys_clk);
        o_intx_valid <= 1'b1;
        {o_intx_src, o_intx_line, o_intx_assert} <= {s, ln, a};
        @(posedge i_sys_clk);
        o_intx_valid <= 1'b0;
        {o_intx_src, o_intx_line, o_intx_assert} <= ~{s, ln, a};
    endtask
    task automatic send_memwr(input rpm_memwr_s m);
        @(posedge i_sys_clk);
        o_memwr_valid <= 1'b1;
        o_memwr <= m;
        @(posedge i_sys_clk);
        o_memwr_valid <= 1'b0;
        o_memwr <= ~m;
    endtask
endmodule // rpm_link_model
`default_nettype wire

/* File: sim/rpm_tb.sv */
// Purpose: Self-checking bench for the root-port message register block
// Assumes: Queue depth 2 so overflow is reached quickly
// Notes: Reads queue their expectation; a monitor compares on accept
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import rpm_pkg::*;
    logic clk, rst_b, root, msi64, link_up, rd_en, wr_en, axi_req, axi_fwd, fwd_en, is_msi, waitreq;
    logic err_v, intx_v, intx_a, mw_v;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, base_hi, base_lo;
    logic [15:0] intx_s, src;
    logic [1:0] intx_l;
    rpm_err_msg_s err_m, em [2];
    rpm_memwr_s mw_m, mw, mw2;
    logic [31:0] exp_q [$];
    int seed = 70754;
    int mismatches = 0;
    int num_checks = 0;
    rpm_root_port_msg_fifo_regs #(.ERR_DEPTH(2), .INT_DEPTH(2)) rpm_root_port_msg_fifo_regs_i (
        .i_sys_clk(clk), .i_rst_b(rst_b), .i_clk_en(1'b1), .i_is_root_port(root), .i_msi_64bit(msi64),
        .i_link_up(link_up), .i_avs_address(addr), .i_avs_read(rd_en), .i_avs_write(wr_en),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_err_msg_valid(err_v), .i_err_msg(err_m),
        .i_intx_msg_valid(intx_v), .i_intx_source_a(intx_s), .i_intx_line(intx_l),
        .i_intx_assert(intx_a), .i_memwr_valid(mw_v), .i_memwr(mw_m), .o_memwr_is_msi(is_msi),
        .i_axi_req(axi_req), .o_axi_forward(axi_fwd), .o_fwd_enable(fwd_en));
    rpm_link_model rpm_link_model_i (.i_sys_clk(clk), .o_err_valid(err_v), .o_err(err_m),
        .o_intx_valid(intx_v), .o_intx_src(intx_s), .o_intx_line(intx_l), .o_intx_assert(intx_a),
        .o_memwr_valid(mw_v), .o_memwr(mw_m));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic close_out;
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Request held until waitrequest is sampled low, then released
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {rd_en, wr_en, addr, wdata} <= {!w, w, a, d};
        do @(posedge clk); while (waitreq !== 1'b0);
        {rd_en, wr_en} <= 2'b00;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, $random(seed));
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        axi_req <= 1'($random(seed));
        if (rd_en && waitreq === 1'b0) chk(rdata, exp_q.pop_front());
    end
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        close_out;
    end
    initial begin
        {rst_b, rd_en, wr_en, addr, wdata, axi_req} = '0;
        {root, msi64, link_up} = 3'b111;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) rd(12'h148 + 12'(4 * i), 32'h0);
        rd(12'h200, 32'h0);
        base_hi = $random(seed);
        bus(1'b1, 12'h14c, base_hi);
        rd(12'h14c, base_hi);
        msi64 <= 1'b0;
        rd(12'h14c, 32'h0);
        msi64 <= 1'b1;
        rd(12'h14c, base_hi);
        bus(1'b1, 12'h150, 32'hffffffff);
        rd(12'h150, 32'hfffff000);
        base_lo = $random(seed) & 32'hfffff000;
        bus(1'b1, 12'h150, base_lo);
        bus(1'b1, 12'h148, 32'h1);
        rd(12'h148, 32'h1);
        chk(32'(fwd_en), 32'h1);
        link_up <= 1'b0;
        repeat (4) @(posedge clk);
        rd(12'h148, 32'h0);
        chk(32'(fwd_en), 32'h0);
        link_up <= 1'b1;
        bus(1'b1, 12'h148, 32'h1);
        root <= 1'b0;
        mw = {base_hi, base_lo, 32'h0};
        rpm_link_model_i.send_memwr(mw);
        @(posedge clk);
        chk(32'(is_msi), 32'h0);
        bus(1'b1, 12'h148, 32'h0);
        for (int i = 0; i < 6; i++) rd(12'h148 + 12'(4 * i), 32'h0);
        root <= 1'b1;
        rd(12'h148, 32'h1);
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 2; k++) begin
                em[k] = {2'(2 * r + k), 16'($random(seed))};
                rpm_link_model_i.send_err(em[k]);
            end
            if (r == 0) rpm_link_model_i.send_err(~em[0]);
            rd(12'h148, {14'h0, r == 0, 1'b1, 16'h1});
            for (int k = 0; k < 2; k++) begin
                rd(12'h154, {13'h0, 1'b1, em[k]});
                rd(12'h154, {13'h0, 1'b1, em[k]});
                bus(1'b1, 12'h154, $random(seed));
            end
            rd(12'h154, 32'h0);
            bus(1'b1, 12'h148, 32'h20001);
        end
        rd(12'h158, 32'h0);
        mw = {base_hi, base_lo + 32'hffc, 16'($random(seed)), 16'($random(seed))};
        mw2 = mw;
        mw2.addr = mw.addr + 64'h4;
        rpm_link_model_i.send_memwr(mw); // Last word inside the window
        @(posedge clk);
        chk(32'(is_msi), 32'h1);
        rpm_link_model_i.send_memwr(mw2); // First word past it, must not queue
        @(posedge clk);
        chk(32'(is_msi), 32'h0);
        for (int l = 0; l < 4; l++) begin
            src = 16'($random(seed));
            rpm_link_model_i.send_intx(src, 2'(l), l[0]);
            if (l == 0) begin
                rpm_link_model_i.send_intx(~src, 2'h3, 1'b1);
                rd(12'h148, 32'hc0001);
                rd(12'h158, {5'b11000, mw.addr[12:2], mw.source_a});
                rd(12'h15c, {16'h0, mw.data});
                bus(1'b1, 12'h15c, 32'h0);
                bus(1'b1, 12'h148, 32'h80001);
            end
            rd(12'h158, {2'b10, l[0], 2'(l), 11'h0, src});
            rd(12'h15c, 32'h0);
            bus(1'b1, 12'h158, $random(seed));
        end
        rd(12'h158, 32'h0);
        rd(12'h148, 32'h1);
        repeat (3) @(posedge clk);
        chk(32'(exp_q.size()), 32'h0);
        close_out;
    end
endmodule // testbench
`default_nettype wire
